/* File: logic/host_bus_defines.svh */
// Offsets, field positions and reset values of the host bus mode and status registers
`ifndef HOST_BUS_DEFINES_SVH
`define HOST_BUS_DEFINES_SVH

// ==========================================================
// Byte mode addresses (full 7-bit host address)
`define WSEL_BYTE_ADDR_LO 7'h00
`define WSEL_BYTE_ADDR_HI 7'h01
`define STAT_BYTE_ADDR_0 7'h04
`define STAT_BYTE_ADDR_1 7'h05
`define STAT_BYTE_ADDR_2 7'h06
`define STAT_BYTE_ADDR_3 7'h07

// ==========================================================
// Word mode addresses (host address bits 6:1)
`define WSEL_WORD_ADDR 6'h00
`define STAT_WORD_ADDR_LO 6'h02
`define STAT_WORD_ADDR_HI 6'h03

// ==========================================================
// Field positions and reset values
`define WSEL_BIT 0
`define WSEL_RESET 1'b0
`define STAT_CFG_LOCK_BIT 0
`define STAT_HOST_LOCK_BIT 1
`define STAT_CFG_FAULT_BIT 2
`define STAT_CARD_FAULT_BIT 3
`define RDATA_RESET 16'h0000

`endif

/* File: logic/host_bus_pkg.sv */
// Types shared by the host bus mode and status logic
`default_nettype none

package host_bus_pkg;

  // ==========================================================
  // Host access request as seen on the port pins
  typedef struct packed {
    logic [6:0] addr;
    logic [15:0] wdata;
    logic rd;
    logic wr;
  } host_req_s;

  // Status inputs from the rest of the controller
  typedef struct packed {
    logic cfg_engine_holds_lock;
    logic host_port_holds_lock;
    logic cfg_engine_fault;
    logic card_ctrl_fault;
  } ctrl_state_s;

  // Decoded register selection
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_WIDTH,
    SEL_STAT_LO,
    SEL_STAT_HI
  } reg_sel_e;

endpackage

`default_nettype wire

/* File: logic/host_addr_decode.sv */
// Address decode of the host port for byte and word modes
`include "host_bus_defines.svh"
`default_nettype none

module host_addr_decode (
  input wire logic [6:0] addr,
  input wire logic word_mode,
  output var host_bus_pkg::reg_sel_e sel,
  output logic upper_byte
);

  // ==========================================================
  // Decode
  // word mode uses bits 6:1
  // status at word 02h-03h or bytes 04h-07h
  always_comb begin
    upper_byte = 1'b0;
    if (word_mode) begin
      if (addr[6:1] == `WSEL_WORD_ADDR) begin
        sel = host_bus_pkg::SEL_WIDTH;
      end else if (addr[6:1] == `STAT_WORD_ADDR_LO) begin
        sel = host_bus_pkg::SEL_STAT_LO;
      end else if (addr[6:1] == `STAT_WORD_ADDR_HI) begin
        sel = host_bus_pkg::SEL_STAT_HI;
      end else begin
        sel = host_bus_pkg::SEL_NONE;
      end
    end else if (addr == `WSEL_BYTE_ADDR_LO || addr == `WSEL_BYTE_ADDR_HI) begin
      // both byte aliases hit one bit
      sel = host_bus_pkg::SEL_WIDTH;
      upper_byte = addr[0];
    end else if (addr == `STAT_BYTE_ADDR_0 || addr == `STAT_BYTE_ADDR_1) begin
      sel = host_bus_pkg::SEL_STAT_LO;
      upper_byte = addr[0];
    end else if (addr == `STAT_BYTE_ADDR_2 || addr == `STAT_BYTE_ADDR_3) begin
      sel = host_bus_pkg::SEL_STAT_HI;
      upper_byte = addr[0];
    end else begin
      sel = host_bus_pkg::SEL_NONE;
    end
  end

endmodule

`default_nettype wire

/* File: logic/host_mode_status.sv */
// Host port bus width select register and low controller status bits
`include "host_bus_defines.svh"
`default_nettype none

module host_mode_status (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire host_bus_pkg::host_req_s req,
  input wire host_bus_pkg::ctrl_state_s ctrl,
  output logic [15:0] rdata,
  output logic [15:0] rdata_oe,
  output logic width_select_bit
);

  typedef struct packed {
    logic wsel;
    logic [15:0] rdata;
    logic [15:0] oe;
  } state_s;

  state_s state_q;
  state_s state_d;
  host_bus_pkg::reg_sel_e sel;
  logic upper_byte;
  logic [31:0] controller_status;

  // ==========================================================
  // Decode
  host_addr_decode u_dec (
    .addr(req.addr),
    .word_mode(state_q.wsel),
    .sel(sel),
    .upper_byte(upper_byte)
  );

  // ==========================================================
  // Status word; upper bits live elsewhere and read zero here
  // lock and fault bits
  always_comb begin
    controller_status = 32'h0000_0000;
    controller_status[`STAT_CFG_LOCK_BIT] = ctrl.cfg_engine_holds_lock;
    controller_status[`STAT_HOST_LOCK_BIT] = ctrl.host_port_holds_lock;
    controller_status[`STAT_CFG_FAULT_BIT] = ctrl.cfg_engine_fault;
    controller_status[`STAT_CARD_FAULT_BIT] = ctrl.card_ctrl_fault;
  end

  // Read data picked by width; byte mode drives only 7:0
  function automatic logic [15:0] pick(input logic [15:0] w, input logic word, input logic hi);
    if (word) begin
      pick = w;
    end else begin
      pick = {8'h00, hi ? w[15:8] : w[7:0]};
    end
  endfunction

  // ==========================================================
  // Next state; read data registered one cycle after rd
  always_comb begin
    state_d = state_q;
    state_d.oe = 16'h0000;
    state_d.rdata = `RDATA_RESET;
    if (req.wr && sel == host_bus_pkg::SEL_WIDTH) begin
      state_d.wsel = req.wdata[`WSEL_BIT];
    end
    if (req.rd && sel != host_bus_pkg::SEL_NONE) begin
      // byte mode enables only low lane
      state_d.oe = state_q.wsel ? 16'hffff : 16'h00ff;
      case (sel)
        host_bus_pkg::SEL_WIDTH: state_d.rdata = {15'h0000, state_q.wsel};
        host_bus_pkg::SEL_STAT_LO:
          state_d.rdata = pick(controller_status[15:0], state_q.wsel, upper_byte);
        host_bus_pkg::SEL_STAT_HI:
          state_d.rdata = pick(controller_status[31:16], state_q.wsel, upper_byte);
        default: state_d.rdata = `RDATA_RESET;
      endcase
    end
  end

  // Registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '{wsel: `WSEL_RESET, rdata: `RDATA_RESET, oe: 16'h0000};
    end else begin
      state_q <= state_d;
    end
  end

  assign rdata = state_q.rdata;
  assign rdata_oe = state_q.oe;
  assign width_select_bit = state_q.wsel;

  // ==========================================================
  // Checks
  sequence s_status_read;
    req.rd && sel == host_bus_pkg::SEL_STAT_LO && state_q.wsel;
  endsequence

  property p_wsel_write;
    @(posedge clk_sys) disable iff (!rst_n)
      req.wr && sel == host_bus_pkg::SEL_WIDTH |=> width_select_bit == $past(req.wdata[0]);
  endproperty
  a_wsel_write: assert property (p_wsel_write) else $error("width bit write lost");

  property p_byte_lane;
    @(posedge clk_sys) disable iff (!rst_n)
      !width_select_bit |-> rdata[15:8] == 8'h00 && rdata_oe[15:8] == 8'h00;
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("high lane used in byte mode");

  property p_word_decode;
    @(posedge clk_sys) disable iff (!rst_n)
      req.rd && state_q.wsel && req.addr[6:1] == 6'h02 |=> rdata_oe == 16'hffff;
  endproperty
  a_word_decode: assert property (p_word_decode) else $error("word status not decoded");

  property p_cfg_lock;
    @(posedge clk_sys) disable iff (!rst_n)
      s_status_read |=> rdata[0] == $past(ctrl.cfg_engine_holds_lock);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock) else $error("cfg lock bit wrong");

  property p_host_lock;
    @(posedge clk_sys) disable iff (!rst_n)
      s_status_read |=> rdata[1] == $past(ctrl.host_port_holds_lock);
  endproperty
  a_host_lock: assert property (p_host_lock) else $error("host lock bit wrong");

  property p_cfg_fault;
    @(posedge clk_sys) disable iff (!rst_n)
      req.rd && !state_q.wsel && req.addr == 7'h04 |=> rdata[2] == $past(ctrl.cfg_engine_fault);
  endproperty
  a_cfg_fault: assert property (p_cfg_fault) else $error("cfg fault bit wrong");

  property p_card_fault;
    @(posedge clk_sys) disable iff (!rst_n)
      s_status_read |=> rdata[3] == $past(ctrl.card_ctrl_fault);
  endproperty
  a_card_fault: assert property (p_card_fault) else $error("card fault bit wrong");

  property p_wsel_reserved;
    @(posedge clk_sys) disable iff (!rst_n)
      req.rd && sel == host_bus_pkg::SEL_WIDTH |=> rdata[15:1] == 15'h0000;
  endproperty
  a_wsel_reserved: assert property (p_wsel_reserved) else $error("reserved bits nonzero");

  property p_status_hi_zero;
    @(posedge clk_sys) disable iff (!rst_n)
      req.rd && !state_q.wsel && req.addr == 7'h05 |=> rdata == 16'h0000;
  endproperty
  a_status_hi_zero: assert property (p_status_hi_zero) else $error("byte 05h nonzero");

  // ==========================================================
  // Step sequences for mode switches and lane use
  sequence s_go_word;
    req.wr && sel == host_bus_pkg::SEL_WIDTH && req.wdata[0];
  endsequence

  sequence s_go_byte;
    req.wr && sel == host_bus_pkg::SEL_WIDTH && !req.wdata[0];
  endsequence

  sequence s_read_any;
    req.rd && sel != host_bus_pkg::SEL_NONE;
  endsequence

  sequence s_byte_read;
    req.rd && !state_q.wsel && sel != host_bus_pkg::SEL_NONE;
  endsequence

  sequence s_word_read;
    req.rd && state_q.wsel && sel != host_bus_pkg::SEL_NONE;
  endsequence

  sequence s_unmapped_read;
    req.rd && sel == host_bus_pkg::SEL_NONE;
  endsequence

  // ==========================================================
  // Lane enables follow the width bit
  property p_byte_oe;
    @(posedge clk_sys) disable iff (!rst_n)
      s_byte_read |=> rdata_oe == 16'h00ff;
  endproperty
  a_byte_oe: assert property (p_byte_oe) else $error("byte lane enable wrong");

  property p_word_oe;
    @(posedge clk_sys) disable iff (!rst_n)
      s_word_read |=> rdata_oe == 16'hffff;
  endproperty
  a_word_oe: assert property (p_word_oe) else $error("word lane enable wrong");

  // New width applies from the very next access
  property p_switch_word;
    @(posedge clk_sys) disable iff (!rst_n)
      s_go_word ##1 s_read_any |=> rdata_oe == 16'hffff;
  endproperty
  a_switch_word: assert property (p_switch_word) else $error("word mode late");

  property p_switch_byte;
    @(posedge clk_sys) disable iff (!rst_n)
      s_go_byte ##1 s_read_any |=> rdata_oe == 16'h00ff;
  endproperty
  a_switch_byte: assert property (p_switch_byte) else $error("byte mode late");

  // Bus stays quiet when nothing is addressed
  property p_unmapped_quiet;
    @(posedge clk_sys) disable iff (!rst_n)
      s_unmapped_read |=> rdata == 16'h0000 && rdata_oe == 16'h0000;
  endproperty
  a_unmapped_quiet: assert property (p_unmapped_quiet) else $error("unmapped read drove");

  property p_idle_quiet;
    @(posedge clk_sys) disable iff (!rst_n)
      !req.rd |=> rdata == 16'h0000 && rdata_oe == 16'h0000;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle bus drove");

  // ==========================================================
  // Width bit aliases and holding
  property p_byte_alias_hi;
    @(posedge clk_sys) disable iff (!rst_n)
      req.wr && !state_q.wsel && req.addr == 7'h01 |=> width_select_bit == $past(req.wdata[0]);
  endproperty
  a_byte_alias_hi: assert property (p_byte_alias_hi) else $error("byte 01h alias lost");

  property p_word_alias;
    @(posedge clk_sys) disable iff (!rst_n)
      req.wr && state_q.wsel && req.addr[6:1] == 6'h00 |=> width_select_bit == $past(req.wdata[0]);
  endproperty
  a_word_alias: assert property (p_word_alias) else $error("word 00h alias lost");

  // Only a width write may move the bit
  property p_width_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      !(req.wr && sel == host_bus_pkg::SEL_WIDTH) |=> $stable(width_select_bit);
  endproperty
  a_width_hold: assert property (p_width_hold) else $error("width bit moved");

  property p_width_read_word;
    @(posedge clk_sys) disable iff (!rst_n)
      req.rd && state_q.wsel && sel == host_bus_pkg::SEL_WIDTH |=> rdata[0] == $past(state_q.wsel);
  endproperty
  a_width_read_word: assert property (p_width_read_word) else $error("width readback wrong");

  // ==========================================================
  // Status bits in byte mode
  property p_byte_cfg_lock;
    @(posedge clk_sys) disable iff (!rst_n)
      req.rd && !state_q.wsel && req.addr == 7'h04 |=> rdata[0] == $past(ctrl.cfg_engine_holds_lock);
  endproperty
  a_byte_cfg_lock: assert property (p_byte_cfg_lock) else $error("byte cfg lock wrong");

  property p_byte_host_lock;
    @(posedge clk_sys) disable iff (!rst_n)
      req.rd && !state_q.wsel && req.addr == 7'h04 |=> rdata[1] == $past(ctrl.host_port_holds_lock);
  endproperty
  a_byte_host_lock: assert property (p_byte_host_lock) else $error("byte host lock wrong");

  property p_byte_card_fault;
    @(posedge clk_sys) disable iff (!rst_n)
      req.rd && !state_q.wsel && req.addr == 7'h04 |=> rdata[3] == $past(ctrl.card_ctrl_fault);
  endproperty
  a_byte_card_fault: assert property (p_byte_card_fault) else $error("byte card fault wrong");

  property p_byte_low_top;
    @(posedge clk_sys) disable iff (!rst_n)
      req.rd && !state_q.wsel && req.addr == 7'h04 |=> rdata[15:4] == 12'h000;
  endproperty
  a_byte_low_top: assert property (p_byte_low_top) else $error("byte 04h top bits set");

  property p_byte_status_top;
    @(posedge clk_sys) disable iff (!rst_n)
      req.rd && !state_q.wsel && (req.addr == 7'h06 || req.addr == 7'h07) |=> rdata == 16'h0000;
  endproperty
  a_byte_status_top: assert property (p_byte_status_top) else $error("byte 06h-07h nonzero");

  // ==========================================================
  // Status bits in word mode
  property p_word_cfg_fault;
    @(posedge clk_sys) disable iff (!rst_n)
      s_status_read |=> rdata[2] == $past(ctrl.cfg_engine_fault);
  endproperty
  a_word_cfg_fault: assert property (p_word_cfg_fault) else $error("word cfg fault wrong");

  property p_word_status_hi;
    @(posedge clk_sys) disable iff (!rst_n)
      req.rd && state_q.wsel && sel == host_bus_pkg::SEL_STAT_HI |=> rdata == 16'h0000;
  endproperty
  a_word_status_hi: assert property (p_word_status_hi) else $error("word 03h nonzero");

  // Status is read only; a write there leaves the width alone
  property p_status_write_ignored;
    @(posedge clk_sys) disable iff (!rst_n)
      req.wr && sel == host_bus_pkg::SEL_STAT_LO |=> $stable(width_select_bit);
  endproperty
  a_status_write_ignored: assert property (p_status_write_ignored) else $error("status write acted");

endmodule

`default_nettype wire

/* File: verification/host_cpu_model.sv */
// Host processor model driving the register port strobes
`default_nettype none

module host_cpu_model (
  input wire logic clk_sys,
  input wire logic [15:0] rdata,
  input wire logic [15:0] rdata_oe,
  output var host_bus_pkg::host_req_s req
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Bus cycles
  initial req = '0;

  task automatic wr_acc(input logic [6:0] a, input logic [15:0] dat);
    @(negedge clk_sys);
    req.addr = a;
    req.wdata = dat;
    req.wr = 1'b1;
    @(negedge clk_sys);
    req.wr = 1'b0;
    req.addr = ~a; // Released lines must not keep the old value
    req.wdata = ~dat;
  endtask

  task automatic rd_acc(input logic [6:0] a, output logic [15:0] dat, output logic [15:0] oe);
    @(negedge clk_sys);
    req.addr = a;
    req.rd = 1'b1;
    @(negedge clk_sys);
    dat = rdata; // Answer stands one cycle only
    oe = rdata_oe;
    req.rd = 1'b0;
    req.addr = ~a;
  endtask
endmodule

`default_nettype wire

/* File: verification/host_bus_mode_and_status_bits_tb.sv */
// Testbench of the host port width select and status bits
`default_nettype none

module host_bus_mode_and_status_bits_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  host_bus_pkg::host_req_s req;
  host_bus_pkg::ctrl_state_s ctrl = '0;
  logic [15:0] rdata, rdata_oe, d, oe;
  logic width_select_bit;
  int fail_count = 0, check_count = 0, cyc = 0;

  // ==========================================================
  // Clock, parts and timeout
  always #12.5 clk_sys = ~clk_sys;

  host_cpu_model host (.clk_sys(clk_sys), .rdata(rdata), .rdata_oe(rdata_oe), .req(req));

  host_mode_status uut (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .ctrl(ctrl),
    .rdata(rdata), .rdata_oe(rdata_oe), .width_select_bit(width_select_bit));

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      give_verdict();
    end
  end

  // ==========================================================
  // Shared helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [15:0] ed, input logic [15:0] eo);
    host.rd_acc(a, d, oe);
    check(d, ed);
    check(oe, eo);
  endtask

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_byte_status();
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_sys);
      ctrl = 4'h8 >> i; // One status source at a time
      rd_chk(7'h04, 16'h0001 << i, 16'h00ff);
    end
    for (int a = 5; a < 8; a++) rd_chk(7'(a), 16'h0000, 16'h00ff);
    rd_chk(7'h02, 16'h0000, 16'h0000);
  endtask

  task automatic t_width_alias();
    host.wr_acc(7'h01, 16'h0001);
    check(16'(width_select_bit), 16'h0001);
    rd_chk(7'h00, 16'h0001, 16'hffff);
    host.wr_acc(7'h00, 16'hfffe);
    check(16'(width_select_bit), 16'h0000);
    host.wr_acc(7'h00, 16'hff01);
    check(16'(width_select_bit), 16'h0001);
  endtask

  task automatic t_word_mode();
    @(negedge clk_sys);
    ctrl = '1;
    rd_chk(7'h04, 16'h000f, 16'hffff);
    rd_chk(7'h05, 16'h000f, 16'hffff);
    rd_chk(7'h06, 16'h0000, 16'hffff);
    rd_chk(7'h02, 16'h0000, 16'h0000);
    host.wr_acc(7'h01, 16'h0000);
    check(16'(width_select_bit), 16'h0000);
    rd_chk(7'h01, 16'h0000, 16'h00ff);
  endtask

  // Status write ignored, then a reset in mid-run drops back to byte mode
  task automatic t_mid_reset();
    host.wr_acc(7'h04, 16'h0001);
    check(16'(width_select_bit), 16'h0000);
    rd_chk(7'h04, 16'h000f, 16'h00ff);
    host.wr_acc(7'h00, 16'h0001);
    check(16'(width_select_bit), 16'h0001);
    @(negedge clk_sys);
    rst_n = 1'b0;
    @(negedge clk_sys);
    check(16'(width_select_bit), 16'h0000);
    check(rdata_oe, 16'h0000);
    rst_n = 1'b1;
    rd_chk(7'h00, 16'h0000, 16'h00ff);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(negedge clk_sys);
    check(16'(width_select_bit), 16'h0000);
    check(rdata_oe, 16'h0000);
    rst_n = 1'b1;
    t_byte_status();
    t_width_alias();
    t_word_mode();
    t_mid_reset();
    give_verdict();
  end
endmodule

`default_nettype wire
